// ### tb/async_tx_last_descriptor_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "atl_consts.svh"
// Runs packets through the engine and judges bytes, write-back and interrupts
module async_tx_last_descriptor_test;
	logic mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, cmd_irq;
	logic mem_req, mem_we, mem_ack, fifo_valid, fifo_last, fifo_ready = 1'b0;
	logic last_bit_sent = 1'b0, rx_or_gap = 1'b0, ack_valid = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, mem_addr, mem_wdata, mem_rdata;
	logic [3:0] mem_be;
	logic [7:0] fifo_data;
	logic [4:0] ack_code = 5'h00, ack_cfg = 5'h11;
	logic [15:0] resp_deadline = 16'h0000;
	logic [8:0] got [$];
	int total_checks = 0, miscompares = 0, irqs = 0, irq0 = 0, gap = 3;
	always #20 mclk = ~mclk;
	atl_engine uut (.mclk, .reset, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_be, .mem_ack, .mem_rdata, .fifo_valid, .fifo_data, .fifo_last,
		.fifo_ready, .last_bit_sent, .rx_or_gap, .ack_valid, .ack_code,
		.second_counter_field(7'h0d), .cycle_tick_field(13'h1abc), .resp_deadline, .cmd_irq);
	atl_mem_model mem (.mclk, .reset, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
		.mem_ack, .mem_rdata);
	// FIFO sink stalls every other cycle; interrupts are counted
	always @(posedge mclk) begin
		fifo_ready <= ~fifo_ready;
		if (fifo_valid === 1'b1 && fifo_ready === 1'b1) got.push_back({fifo_last, fifo_data});
		if (cmd_irq === 1'b1) irqs++;
	end
	// Link side: last bit out, then reply or gap after gap cycles, then the acknowledge
	always @(posedge mclk) begin
		if (fifo_valid === 1'b1 && fifo_ready === 1'b1 && fifo_last === 1'b1) begin
			repeat (2) @(posedge mclk);
			last_bit_sent <= 1'b1;
			@(posedge mclk);
			last_bit_sent <= 1'b0;
			repeat (gap - 1) @(posedge mclk);
			rx_or_gap <= 1'b1;
			@(posedge mclk);
			rx_or_gap <= 1'b0;
			ack_valid <= 1'b1;
			ack_code <= ack_cfg;
			@(posedge mclk);
			ack_valid <= 1'b0;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One word transfer, held until hready is seen high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// Final fetch word: key zero, branch control three
	function automatic logic [31:0] cmdw(input logic [1:0] i, input logic p, input logic [15:0] n);
		return {4'h1, 4'h0, p, 1'b0, i, 2'b11, 2'b00, n};
	endfunction : cmdw
	// Block of two at 0x100, last descriptor aligned at 0x110
	task automatic pkt(input logic [31:0] w0, input logic [31:0] w2, input logic rs,
		input logic [4:0] ak, input int nw);
		logic [31:0] d;
		int w;
		got.delete();
		ack_cfg = ak;
		irq0 = irqs;
		mem.ram[8'h44] = w0;
		mem.ram[8'h45] = 32'h00000301;
		mem.ram[8'h46] = w2;
		mem.ram[8'h47] = 32'h5555aaaa;
		w = mem.wr_n + nw;
		ahb(1'b1, `ATL_REG_CTRL, 32'h0, d);
		ahb(1'b1, `ATL_REG_DESC, 32'h00000102, d);
		ahb(1'b1, `ATL_REG_CTRL, {30'h0, rs, 1'b1}, d);
		while (mem.wr_n < w) @(posedge mclk);
		repeat (4) @(posedge mclk);
	endtask : pkt
	task automatic t_regs;
		logic [31:0] d;
		ahb(1'b0, 8'h10, 32'h0, d);
		chk(d, 32'h0);
		ahb(1'b0, `ATL_REG_STAT, 32'h0, d);
		chk(d, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_request;
		logic [31:0] d;
		// Next block of three at 0x200, its last at 0x220, ending the list
		mem.ram[8'h88] = cmdw(2'b00, 1'b0, 16'h0);
		mem.ram[8'h89] = 32'h00000300;
		mem.ram[8'h8a] = 32'h0;
		pkt(cmdw(2'b11, 1'b0, 16'd5), 32'h00000203, 1'b0, 5'h11, 2);
		chk(32'(got.size()), 6);
		for (int k = 0; k < 5; k++) chk(32'(got[k]), {k == 4, 8'((k + 1) * 17)});
		chk(32'(got[5]), 32'h100);
		chk(mem.ram[8'h47][15:0], 16'hbabc);
		chk(mem.ram[8'h47][31:16] & 16'h801f, 16'h8011);
		chk(irqs - irq0, 1);
		ahb(1'b0, `ATL_REG_TAG, 32'h0, d);
		chk(d, 32'h0000babc);
		repeat (20) @(posedge mclk);
		chk(32'(mem_req), 0);
		$display("test request done");
	endtask : t_request
	task automatic t_irq;
		logic [1:0] ic [5] = '{2'b00, 2'b01, 2'b01, 2'b01, 2'b10};
		logic [4:0] ak [5] = '{5'h1b, 5'h11, 5'h12, 5'h1b, 5'h1b};
		int ex [5] = '{0, 0, 0, 1, 0};
		for (int k = 0; k < 5; k++) begin
			pkt(cmdw(ic[k], 1'b0, 16'h0), 32'h0, 1'b0, ak[k], 1);
			chk(irqs - irq0, ex[k]);
			chk(32'(got[0]), 32'h100);
		end
		$display("test interrupt control done");
	endtask : t_irq
	task automatic t_ping;
		gap = 9;
		pkt(cmdw(2'b11, 1'b1, 16'd2), 32'h0, 1'b0, 5'h11, 1);
		chk(mem.ram[8'h47][15:0], 16'd9);
		gap = 3;
		$display("test ping done");
	endtask : t_ping
	task automatic t_resp;
		resp_deadline <= 16'hc000;
		pkt(cmdw(2'b11, 1'b0, 16'd1), 32'h0, 1'b1, 5'h11, 1);
		chk(32'(got.size()), 1);
		chk(mem.ram[8'h47][15:0], 16'haaaa);
		resp_deadline <= 16'hbab0;
		pkt(cmdw(2'b11, 1'b0, 16'd1), 32'h0, 1'b1, 5'h11, 1);
		chk(32'(got.size()), 0);
		chk(mem.ram[8'h47][20:16], 5'h0f);
		$display("test response done");
	endtask : t_resp
	task automatic t_dead;
		logic [31:0] d;
		logic [31:0] c0 [3] = '{32'h203c0001, 32'h123c0001, 32'h103c0001};
		logic [31:0] br [3] = '{32'h0, 32'h0, 32'h00000201};
		logic [4:0] ev [3] = '{5'h0e, 5'h0e, 5'h0d};
		for (int k = 0; k < 3; k++) begin
			pkt(c0[k], br[k], 1'b0, 5'h11, 0);
			repeat (60) @(posedge mclk);
			ahb(1'b0, `ATL_REG_STAT, 32'h0, d);
			chk({d[11], d[4:0]}, {1'b1, ev[k]});
			if (k < 2) chk(32'(got.size()), 0);
		end
		$display("test refused descriptors done");
	endtask : t_dead
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		mem.ram[8'hc0] = 32'h33221100;
		mem.ram[8'hc1] = 32'h77665544;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_request;
		t_irq;
		t_ping;
		t_resp;
		t_dead;
		results;
	end
	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		results;
	end
endmodule : async_tx_last_descriptor_test
`default_nettype wire

// ### tb/atl_engine_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the final fetch engine
module atl_engine_properties (
	input wire logic mclk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [1:0] htrans,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] mem_be,
	input wire logic mem_ack,
	input wire logic fifo_valid,
	input wire logic [7:0] fifo_data,
	input wire logic fifo_last,
	input wire logic fifo_ready,
	input wire logic cmd_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Bus answers after exactly one wait state
	chk_bus_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("bus answer late");
	chk_okay_resp: assert property (hresp == 1'b0) else $error("bus response not okay");
	chk_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("memory request dropped");
	// The three descriptor words run back to back on one held request, one word apart
	chk_req_drop: assert property (mem_req && mem_ack |=> !mem_req
		|| (!mem_we && mem_addr == $past(mem_addr) + 32'h00000004))
		else $error("memory request kept");
	chk_word_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("unaligned fetch");
	// Stalled byte must wait unchanged
	chk_byte_held: assert property (fifo_valid && !fifo_ready |=> fifo_valid
		&& $stable({fifo_data, fifo_last}))
		else $error("byte changed under stall");
	chk_wb_slot: assert property (mem_req && mem_we |-> mem_addr[3:0] == 4'hc
		&& (mem_be == 4'hf || mem_be == 4'hc))
		else $error("write-back slot wrong");
	chk_irq_cause: assert property (cmd_irq |-> $past(mem_ack) && $past(mem_we) && !$past(cmd_irq))
		else $error("interrupt without write-back");
	cover property (fifo_valid && fifo_ready && fifo_last);
	cover property (cmd_irq);
	cover property (mem_req && mem_we && mem_be == 4'hc);
endmodule : atl_engine_properties

bind atl_engine atl_engine_properties chk (.mclk, .reset, .hsel, .hready, .htrans, .hreadyout,
	.hresp, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_ack, .fifo_valid, .fifo_data,
	.fifo_last, .fifo_ready, .cmd_irq);
`default_nettype wire

// ### tb/atl_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host memory holding descriptor lists and packet buffers
module atl_mem_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] ram [0:255];
	logic [1:0] cnt;
	logic slow;
	int wr_n;
	// Prompt and slow answers alternate; idle data keep changing so stale reads show
	always @(posedge mclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (reset) begin
			cnt <= 2'd0;
			slow <= 1'b0;
			wr_n <= 0;
			mem_rdata <= 32'h5a5a5a5a;
		end else if (mem_req && !mem_ack) begin
			cnt <= cnt + 2'd1;
			if (cnt == {slow, 1'b0}) begin
				cnt <= 2'd0;
				slow <= ~slow;
				mem_ack <= 1'b1;
				mem_rdata <= ram[mem_addr[9:2]];
				if (mem_we) begin
					wr_n <= wr_n + 1;
					for (int b = 0; b < 4; b++) begin
						if (mem_be[b]) ram[mem_addr[9:2]][8*b+:8] <= mem_wdata[8*b+:8];
					end
				end
			end
		end
	end
endmodule : atl_mem_model
`default_nettype wire

// ### verilog/atl_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "atl_consts.svh"

// AHB-Lite slave with one wait state so that read data leave a flip-flop
module atl_ahb_slave (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] rd_value,
	output logic [7:0] reg_addr,
	output logic wr_pulse,
	output logic [31:0] wr_data,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	import atl_pkg::*;

	atl_bus_t s_reg;
	atl_bus_t s_next;

	// Only word writes take effect; other writes are accepted and ignored, reads of any size return data
	always_comb begin
		s_next = s_reg;
		s_next.wr_pulse = 1'b0;
		case (s_reg.st)
			ATL_BUS_IDLE: begin
				if (hsel && hready && htrans[1]) begin
					s_next.st = ATL_BUS_WAIT;
					s_next.wr = hwrite && (hsize == 3'h2);
					s_next.addr = haddr[7:0];
					s_next.hreadyout = 1'b0;
				end
			end
			ATL_BUS_WAIT: begin
				// Write data is on the bus during this wait cycle
				s_next.wr_pulse = s_reg.wr;
				s_next.wdata = hwdata;
				s_next.hrdata = s_reg.wr ? 32'h00000000 : rd_value;
				s_next.hreadyout = 1'b1;
				s_next.st = ATL_BUS_DONE;
			end
			ATL_BUS_DONE: begin
				s_next.st = ATL_BUS_IDLE;
				if (hsel && htrans[1]) begin
					s_next.st = ATL_BUS_WAIT;
					s_next.wr = hwrite && (hsize == 3'h2);
					s_next.addr = haddr[7:0];
					s_next.hreadyout = 1'b0;
				end
			end
			default: s_next.st = ATL_BUS_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.hreadyout <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign reg_addr = s_reg.addr;
	assign wr_pulse = s_reg.wr_pulse;
	assign wr_data = s_reg.wdata;
	assign hreadyout = s_reg.hreadyout;
	assign hrdata = s_reg.hrdata;
	assign hresp = 1'b0;
endmodule : atl_ahb_slave
`default_nettype wire

// ### verilog/atl_consts.svh
`ifndef ATL_CONSTS_SVH
`define ATL_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave
`define ATL_REG_CTRL 8'h00
`define ATL_REG_DESC 8'h04
`define ATL_REG_STAT 8'h08
`define ATL_REG_TAG 8'h0c
// Control register bits
`define ATL_CTRL_RUN 0
`define ATL_CTRL_RESP 1
// Descriptor word 0 fields
`define ATL_D0_CMD_HI 31
`define ATL_D0_CMD_LO 28
`define ATL_D0_KEY_HI 26
`define ATL_D0_KEY_LO 24
`define ATL_D0_PING 23
`define ATL_D0_INT_HI 21
`define ATL_D0_INT_LO 20
`define ATL_D0_BR_HI 19
`define ATL_D0_BR_LO 18
// Command and key of the final fetch command
`define ATL_CMD_LAST 4'h1
`define ATL_KEY_LAST 3'h0
// Interrupt control codes
`define ATL_INT_ALWAYS 2'b11
`define ATL_INT_ERR 2'b01
`define ATL_INT_NEVER 2'b00
// Next-block count limits
`define ATL_Z_END 4'h0
`define ATL_Z_MIN 4'h2
`define ATL_Z_MAX 4'h8
// Acknowledge and event codes
`define ATL_ACK_COMPLETE 5'h11
`define ATL_ACK_PENDING 5'h12
`define ATL_EVT_NONE 5'h00
`define ATL_EVT_FLUSHED 5'h0f
`define ATL_EVT_BAD_CMD 5'h0e
`define ATL_EVT_BAD_Z 5'h0d
// Context state bit positions
`define ATL_CTX_RUN 15
`define ATL_CTX_DEAD 11
`define ATL_CTX_ACTIVE 10
// Write-back lanes of descriptor word 3: outcome high half, time tag low half
`define ATL_BE_ALL 4'hf
`define ATL_BE_OUTCOME 4'hc
`define ATL_DESC_BYTES 32'h00000010

`endif

// ### verilog/atl_engine.sv
// Functional notes
// - Command code one selects final fetch
// - Key zero with command selects final fetch
// - Last byte closes the packet in FIFO
// - Move byte count from buffer pointer
// - Ping flag one marks a ping packet
// - Ping tag is last bit to reply
// - Interrupt control 11 always interrupts
// - Control 01 interrupts unless complete or pending
// - Control 00 never interrupts; 10 unused
// - Next pointer is 16-byte aligned address
// - Next count zero ends; else 2..8
// - Immediate counts two blocks, others one
// - Write context state low half back
// - Tag is three seconds bits, 13 cycle bits
// - Requests get transmission time written back
// - Responses leave the tag field alone
// - Expired responses are not transmitted
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "atl_consts.svh"

module atl_engine (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [3:0] mem_be,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic fifo_valid,
	output logic [7:0] fifo_data,
	output logic fifo_last,
	input wire logic fifo_ready,
	input wire logic last_bit_sent,
	input wire logic rx_or_gap,
	input wire logic ack_valid,
	input wire logic [4:0] ack_code,
	input wire logic [6:0] second_counter_field,
	input wire logic [12:0] cycle_tick_field,
	input wire logic [15:0] resp_deadline,
	output logic cmd_irq
);
	import atl_pkg::*;

	atl_eng_t e_reg;
	atl_eng_t e_next;
	logic [7:0] reg_addr;
	logic wr_pulse;
	logic [31:0] wr_data;
	logic [31:0] rd_value;
	logic tag_done;
	logic [15:0] tag;
	logic [15:0] now_tag;
	logic [15:0] late_by;
	logic expired;
	logic [15:0] ctx_state;
	logic ack_ok;
	logic [3:0] d_cmd;
	logic [2:0] d_key;
	logic [1:0] d_int;

	atl_ahb_slave u_bus (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.rd_value(rd_value),
		.reg_addr(reg_addr),
		.wr_pulse(wr_pulse),
		.wr_data(wr_data),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp)
	);

	atl_time_tag u_tag (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.arm(e_reg.tag_arm),
		.ping(e_reg.d0[`ATL_D0_PING]),
		.last_bit_sent(last_bit_sent),
		.rx_or_gap(rx_or_gap),
		.second_counter_field(second_counter_field),
		.cycle_tick_field(cycle_tick_field),
		.tag_done(tag_done),
		.tag(tag)
	);

	// Descriptor fields and derived conditions
	assign d_cmd = e_reg.d0[`ATL_D0_CMD_HI:`ATL_D0_CMD_LO];
	assign d_key = e_reg.d0[`ATL_D0_KEY_HI:`ATL_D0_KEY_LO];
	assign d_int = e_reg.d0[`ATL_D0_INT_HI:`ATL_D0_INT_LO];
	assign now_tag = {second_counter_field[2:0], cycle_tick_field};
	// Wrapping compare: late when now is ahead of the deadline by under half the range
	assign late_by = now_tag - resp_deadline;
	assign expired = (late_by != 16'h0000) && !late_by[15];
	assign ack_ok = (e_reg.evt == `ATL_ACK_COMPLETE) || (e_reg.evt == `ATL_ACK_PENDING);
	assign ctx_state = {e_reg.run, 3'b000, e_reg.dead, (e_reg.st != ATL_IDLE), 5'b00000,
		e_reg.evt};

	// Register read mux, registered again in the bus slave
	always_comb begin
		case (reg_addr)
			`ATL_REG_CTRL: rd_value = {30'h00000000, e_reg.resp_ctx, e_reg.run};
			`ATL_REG_DESC: rd_value = {e_reg.desc_ptr, e_reg.zcnt};
			`ATL_REG_STAT: rd_value = {12'h000, e_reg.st, ctx_state};
			`ATL_REG_TAG: rd_value = {16'h0000, e_reg.last_tag};
			default: rd_value = 32'h00000000;
		endcase
	end

	// Descriptor engine: fetch, move bytes, wait for ack, write back, follow branch
	always_comb begin
		e_next = e_reg;
		e_next.irq = 1'b0;
		e_next.tag_arm = 1'b0;
		if (wr_pulse && reg_addr == `ATL_REG_CTRL) begin
			e_next.run = wr_data[`ATL_CTRL_RUN];
			e_next.resp_ctx = wr_data[`ATL_CTRL_RESP];
			if (!wr_data[`ATL_CTRL_RUN]) begin
				e_next.dead = 1'b0;
			end
		end
		// The pointer is only taken while idle, including the one ATL_IDLE cycle a running list passes between blocks
		if (wr_pulse && reg_addr == `ATL_REG_DESC && e_reg.st == ATL_IDLE) begin
			e_next.desc_ptr = wr_data[31:4];
			e_next.zcnt = wr_data[3:0];
		end
		if (ack_valid && e_reg.st == ATL_WAIT_ACK) begin
			e_next.ack_seen = 1'b1;
			e_next.evt = ack_code;
		end
		case (e_reg.st)
			ATL_IDLE: begin
				if (e_reg.run && !e_reg.dead && e_reg.zcnt != `ATL_Z_END) begin
					// Last descriptor of the block sits (Z-1) blocks in
					e_next.mem_addr = {e_reg.desc_ptr + {24'h000000, e_reg.zcnt - 4'h1}, 4'h0};
					e_next.mem_req = 1'b1;
					e_next.mem_we = 1'b0;
					e_next.mem_be = `ATL_BE_ALL;
					e_next.widx = 2'b00;
					e_next.evt = `ATL_EVT_NONE;
					e_next.st = ATL_FETCH;
				end
			end
			ATL_FETCH: begin
				if (mem_ack) begin
					case (e_reg.widx)
						2'b00: e_next.d0 = mem_rdata;
						2'b01: e_next.baddr = mem_rdata;
						2'b10: e_next.branch = mem_rdata;
						default: e_next.d0 = e_reg.d0;
					endcase
					if (e_reg.widx == 2'b10) begin
						e_next.mem_req = 1'b0;
						e_next.st = ATL_DECODE;
					end else begin
						e_next.widx = e_reg.widx + 2'b01;
						e_next.mem_addr = e_reg.mem_addr + 32'h00000004;
					end
				end
			end
			ATL_DECODE: begin
				e_next.left = e_reg.d0[15:0];
				e_next.tag_arm = 1'b1;
				e_next.ack_seen = 1'b0;
				if (d_cmd != `ATL_CMD_LAST || d_key != `ATL_KEY_LAST) begin
					e_next.evt = `ATL_EVT_BAD_CMD;
					e_next.dead = 1'b1;
					e_next.st = ATL_DEAD;
				end else if (e_reg.resp_ctx && expired) begin
					e_next.evt = `ATL_EVT_FLUSHED;
					e_next.st = ATL_WB;
				end else if (e_reg.d0[15:0] == 16'h0000) begin
					// Empty buffer still closes the packet on a dummy zero byte
					e_next.fifo_data = 8'h00;
					e_next.fifo_last = 1'b1;
					e_next.fifo_valid = 1'b1;
					e_next.st = ATL_PUSH;
				end else begin
					e_next.mem_addr = {e_reg.baddr[31:2], 2'b00};
					e_next.mem_req = 1'b1;
					e_next.st = ATL_RD_BYTE;
				end
			end
			ATL_RD_BYTE: begin
				if (mem_ack) begin
					e_next.mem_req = 1'b0;
					e_next.fifo_data = mem_rdata[{e_reg.baddr[1:0], 3'b000} +: 8];
					e_next.fifo_last = (e_reg.left == 16'h0001);
					e_next.fifo_valid = 1'b1;
					e_next.baddr = e_reg.baddr + 32'h00000001;
					e_next.left = e_reg.left - 16'h0001;
					e_next.st = ATL_PUSH;
				end
			end
			ATL_PUSH: begin
				if (fifo_ready) begin
					e_next.fifo_valid = 1'b0;
					if (e_reg.fifo_last) begin
						e_next.st = ATL_WAIT_ACK;
					end else begin
						e_next.mem_addr = {e_reg.baddr[31:2], 2'b00};
						e_next.mem_req = 1'b1;
						e_next.st = ATL_RD_BYTE;
					end
				end
			end
			ATL_WAIT_ACK: begin
				// Responses need no tag; requests and pings wait for it
				if (e_reg.ack_seen && (tag_done || e_reg.resp_ctx)) begin
					e_next.st = ATL_WB;
				end
			end
			ATL_WB: begin
				if (!e_reg.mem_req) begin
					e_next.mem_req = 1'b1;
					e_next.mem_we = 1'b1;
					e_next.mem_addr = {e_reg.desc_ptr + {24'h000000, e_reg.zcnt - 4'h1}, 4'hc};
					e_next.mem_wdata = {ctx_state, tag};
					e_next.mem_be = e_reg.resp_ctx ? `ATL_BE_OUTCOME : `ATL_BE_ALL;
					if (!e_reg.resp_ctx) begin
						e_next.last_tag = tag;
					end
				end else if (mem_ack) begin
					e_next.mem_req = 1'b0;
					e_next.mem_we = 1'b0;
					e_next.mem_be = `ATL_BE_ALL;
					case (d_int)
						`ATL_INT_ALWAYS: e_next.irq = 1'b1;
						`ATL_INT_ERR: e_next.irq = !ack_ok;
						default: e_next.irq = 1'b0;
					endcase
					e_next.st = ATL_NEXT;
				end
			end
			ATL_NEXT: begin
				e_next.desc_ptr = e_reg.branch[31:4];
				e_next.zcnt = e_reg.branch[3:0];
				if (e_reg.branch[3:0] == `ATL_Z_END) begin
					e_next.st = ATL_IDLE;
				end else if (e_reg.branch[3:0] < `ATL_Z_MIN || e_reg.branch[3:0] > `ATL_Z_MAX) begin
					e_next.evt = `ATL_EVT_BAD_Z;
					e_next.dead = 1'b1;
					e_next.st = ATL_DEAD;
				end else begin
					e_next.st = ATL_IDLE;
				end
			end
			ATL_DEAD: begin
				// Only clearing run releases a dead context
				if (!e_reg.run) begin
					e_next.st = ATL_IDLE;
				end
			end
			default: e_next.st = ATL_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			e_reg <= '0;
			e_reg.mem_be <= `ATL_BE_ALL;
		end else if (ce) begin
			e_reg <= e_next;
		end
	end

	// Outputs straight from the state register
	assign mem_req = e_reg.mem_req;
	assign mem_we = e_reg.mem_we;
	assign mem_addr = e_reg.mem_addr;
	assign mem_wdata = e_reg.mem_wdata;
	assign mem_be = e_reg.mem_be;
	assign fifo_valid = e_reg.fifo_valid;
	assign fifo_data = e_reg.fifo_data;
	assign fifo_last = e_reg.fifo_last;
	assign cmd_irq = e_reg.irq;
endmodule : atl_engine
`default_nettype wire

// ### verilog/atl_pkg.sv
package atl_pkg;
	typedef enum logic [3:0] {
		ATL_IDLE = 4'b0000,
		ATL_FETCH = 4'b0001,
		ATL_DECODE = 4'b0010,
		ATL_RD_BYTE = 4'b0011,
		ATL_PUSH = 4'b0100,
		ATL_WAIT_ACK = 4'b0101,
		ATL_WB = 4'b0110,
		ATL_NEXT = 4'b0111,
		ATL_DEAD = 4'b1000
	} atl_state_t;

	typedef enum logic [1:0] {
		ATL_BUS_IDLE = 2'b00,
		ATL_BUS_WAIT = 2'b01,
		ATL_BUS_DONE = 2'b10
	} atl_bus_state_t;

	typedef struct packed {
		atl_bus_state_t st;
		logic wr;
		logic [7:0] addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic wr_pulse;
		logic [31:0] wdata;
	} atl_bus_t;

	typedef struct packed {
		logic counting;
		logic done;
		logic [15:0] tag;
	} atl_tag_t;

	typedef struct packed {
		atl_state_t st;
		logic run;
		logic resp_ctx;
		logic [27:0] desc_ptr;
		logic [3:0] zcnt;
		logic [1:0] widx;
		logic [31:0] d0;
		logic [31:0] baddr;
		logic [31:0] branch;
		logic [15:0] left;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic [3:0] mem_be;
		logic fifo_valid;
		logic [7:0] fifo_data;
		logic fifo_last;
		logic [4:0] evt;
		logic ack_seen;
		logic dead;
		logic irq;
		logic tag_arm;
		logic [15:0] last_tag;
	} atl_eng_t;
endpackage : atl_pkg

// ### verilog/atl_time_tag.sv
`timescale 1ns/1ps
`default_nettype none
`include "atl_consts.svh"

// Forms the send time tag: a timer snapshot, or the ping round-trip interval
module atl_time_tag (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic arm,
	input wire logic ping,
	input wire logic last_bit_sent,
	input wire logic rx_or_gap,
	input wire logic [6:0] second_counter_field,
	input wire logic [12:0] cycle_tick_field,
	output logic tag_done,
	output logic [15:0] tag
);
	import atl_pkg::*;

	atl_tag_t t_reg;
	atl_tag_t t_next;

	always_comb begin
		t_next = t_reg;
		if (arm) begin
			t_next = '0;
		end else if (!t_reg.done && !t_reg.counting && last_bit_sent) begin
			if (ping) begin
				t_next.counting = 1'b1;
			end else begin
				t_next.tag = {second_counter_field[2:0], cycle_tick_field};
				t_next.done = 1'b1;
			end
		end else if (t_reg.counting) begin
			// Interval in mclk cycles, held at full scale rather than wrapping
			if (t_reg.tag != 16'hffff) begin
				t_next.tag = t_reg.tag + 16'h0001;
			end
			if (rx_or_gap) begin
				t_next.counting = 1'b0;
				t_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			t_reg <= '0;
		end else if (ce) begin
			t_reg <= t_next;
		end
	end

	assign tag_done = t_reg.done;
	assign tag = t_reg.tag;
endmodule : atl_time_tag
`default_nettype wire
